// ---- shared/ftm_pkg.sv ----
// constants for the flexible tdm input byte mapper
// assumes word-wide apb access with byte address = 4 * register index
package ftm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map (indices; byte address is four times the index)
    localparam logic [15:0] MAP_BASE_IDX = 16'hf300; // first map entry
    localparam logic [15:0] MAP_LAST_IDX = 16'hf33f; // last map entry
    localparam logic [15:0] STAT_IDX = 16'hf340;     // frame status
    localparam int ADDR_W = 18;                      // apb byte address
    localparam int IDX_LSB = 2;                      // word index low bit

    ////////////////////////////////////////////////////////////////////////
    // mapping entry fields
    localparam int ENTRY_W = 8;             // stored entry bits
    localparam int ENABLE_BIT = 7;          // slot enable
    localparam int REVERSE_BIT = 6;         // bit order mirror
    localparam int PIN_BIT = 5;             // source pin select
    localparam int POS_HI = 4;              // channel position msb
    localparam int POS_LO = 2;              // channel position lsb
    localparam int LANE_HI = 1;             // byte lane msb
    localparam int LANE_LO = 0;             // byte lane lsb
    localparam logic [ENTRY_W-1:0] ENTRY_RST = 8'h00; // entry reset

    ////////////////////////////////////////////////////////////////////////
    // stream geometry
    localparam int SLOTS = 64;              // byte slots per frame
    localparam int CHANS = 16;              // assembled channels
    localparam int CHAN_W = 32;             // channel width
    localparam int BYTE_W = 8;              // slot width
    localparam int LANES = 4;               // bytes per channel
    localparam int BIT_CNT_W = 9;           // bits per frame counter
    localparam logic [2:0] LAST_BIT = 3'h7; // last bit of a byte
    localparam int FRAME_CNT_W = 16;        // status frame counter
    localparam int CHAN_BASE_A = 32;        // channel number of pin a base
    localparam int CHAN_BASE_B = 40;        // channel number of pin b base

endpackage : ftm_pkg

// ---- hdl/ftm_input_mapper.sv ----
// flexible tdm input byte mapper: apb map registers, pin sampling,
// byte assembly into sixteen 32-bit input channels
// assumes bit clock and frame sync arrive on pins much slower than clk
`timescale 1ns/100ps

module ftm_input_mapper
    import ftm_pkg::*;
#(
    parameter int NUM_SLOTS = SLOTS,    // map entries
    parameter int NUM_CHANS = CHANS     // assembled channels
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic bitClk,
    input wire logic frameSync,
    input wire logic flex_serial_input_a,
    input wire logic flex_serial_input_b,
    // channel side toward the core
    output logic [NUM_CHANS*CHAN_W-1:0] chanData,
    output logic chanUpdate
);

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [3:0] sync1;                          // first sync stage
        logic [3:0] sync2;                          // second sync stage
        logic bitClkPrev;                           // bit clock history
        logic fsPrev;                               // sync at last bit edge
        logic inFrame;                              // frame under way
        logic framed; // a frame start was seen
        logic [BIT_CNT_W-1:0] bitCnt;               // bit within frame
        logic [BYTE_W-1:0] shiftA;                  // pin a shifter
        logic [BYTE_W-1:0] shiftB;                  // pin b shifter
        logic [NUM_SLOTS-1:0][ENTRY_W-1:0] slotMap; // map entries
        logic [NUM_CHANS-1:0][CHAN_W-1:0] build;    // channels in progress
        logic [NUM_CHANS*CHAN_W-1:0] chanOut;       // published channels
        logic chanPulse;                            // publish pulse
        logic [FRAME_CNT_W-1:0] frameCnt;           // frames seen
        logic [31:0] rdata;                         // apb read data
        logic ready;                                // apb ready
        logic slvErr;                               // apb error
    } ftm_state_t;

    ftm_state_t st_q; // registered state
    ftm_state_t st_d; // next state

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // mirror byte bit order
    // swaps the msb and lsb ends of a slot byte before it is stored
    function automatic logic [BYTE_W-1:0] mirror(
        input logic [BYTE_W-1:0] b
    );
        logic [BYTE_W-1:0] r;
        r = '0;
        for (int i = 0; i < BYTE_W; i++) begin
            r[i] = b[BYTE_W-1-i];
        end
        return r;
    endfunction

    // word index of the apb address
    logic [15:0] idx; // register index
    assign idx = paddr[ADDR_W-1:IDX_LSB];

    // map hit and entry number
    // entries sit at consecutive indices from the map base
    logic mapHit; // index inside map window
    logic statHit; // status register
    logic [5:0] entryNo; // entry addressed
    assign mapHit = (idx >= MAP_BASE_IDX) && (idx <= MAP_LAST_IDX);
    assign statHit = (idx == STAT_IDX);
    assign entryNo = 6'(idx - MAP_BASE_IDX);

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic bitRise;
        logic frameStart;
        logic [BIT_CNT_W-1:0] cnt;
        logic [BYTE_W-1:0] nextA;
        logic [BYTE_W-1:0] nextB;
        logic [ENTRY_W-1:0] ent;
        logic [BYTE_W-1:0] slotByte;
        logic [3:0] ch;
        logic [1:0] lane;
        bitRise = 1'b0;
        frameStart = 1'b0;
        cnt = '0;
        nextA = '0;
        nextB = '0;
        ent = '0;
        slotByte = '0;
        ch = '0;
        lane = '0;
        st_d = st_q;
        st_d.chanPulse = 1'b0;

        // pin synchronisers: bitClk, frameSync, a, b
        // only the second stage feeds logic; the first may be metastable
        // all four pins share stages, so data and sync stay aligned
        st_d.sync1 = {bitClk, frameSync, flex_serial_input_a,
                      flex_serial_input_b};
        st_d.sync2 = st_q.sync1;
        // one-clk pulse on a rise of the synchronised bit clock
        st_d.bitClkPrev = st_q.sync2[3];
        bitRise = st_q.sync2[3] && !st_q.bitClkPrev;

        // serial side, one step per bit clock rising edge
        if (bitRise) begin
            st_d.fsPrev = st_q.sync2[2];
            frameStart = st_q.sync2[2] && !st_q.fsPrev;
            nextA = {st_q.shiftA[BYTE_W-2:0], st_q.sync2[1]};
            nextB = {st_q.shiftB[BYTE_W-2:0], st_q.sync2[0]};
            st_d.shiftA = nextA;
            st_d.shiftB = nextB;
            if (frameStart) begin
                // publish last frame, start a clean build
                // inFrame drops after bit 511, so it cannot tell whether
                // a frame was ever built; framed stays set from then on
                if (st_q.framed) begin
                    // previous frame complete or cut short: hand it over
                    st_d.chanOut = st_q.build;
                end
                st_d.chanPulse = st_q.framed;
                st_d.framed = 1'b1;
                // lanes no enabled slot writes this frame read zero
                st_d.build = '0;
                st_d.inFrame = 1'b1;
                st_d.frameCnt = st_q.frameCnt + 1'b1;
                cnt = '0;
            end else begin
                cnt = st_q.bitCnt;
            end
            if (st_d.inFrame) begin
                if (cnt[2:0] == LAST_BIT) begin
                    // byte complete: slot number is the byte index
                    ent = st_q.slotMap[cnt[BIT_CNT_W-1:3]];
                    slotByte = ent[PIN_BIT] ? nextB : nextA;
                    if (ent[REVERSE_BIT]) begin
                        slotByte = mirror(slotByte);
                    end
                    ch = {ent[PIN_BIT], ent[POS_HI:POS_LO]};
                    lane = ent[LANE_HI:LANE_LO];
                    // a disabled slot leaves its lane untouched
                    // two slots on one lane: the later slot wins
                    if (ent[ENABLE_BIT]) begin
                        // lane 0 is the top byte
                        st_d.build[ch][(2'h3 - lane)*BYTE_W +: BYTE_W] =
                            slotByte;
                    end
                end
                st_d.bitCnt = cnt + 1'b1;
                // last bit of the frame ends it until the next sync
                // later bits are ignored until the next sync rise
                if (cnt == {BIT_CNT_W{1'b1}}) begin
                    st_d.inFrame = 1'b0;
                end
            end
        end

        // apb: answer in the access phase, act at its completing edge
        // read data is captured at setup, so it stands exactly while
        // pready is high; no wait state is ever inserted
        st_d.ready = 1'b0;
        st_d.slvErr = 1'b0;
        if (psel && !penable) begin
            st_d.ready = 1'b1;
            st_d.slvErr = !(mapHit || statHit);
            if (mapHit) begin
                st_d.rdata = {24'h000000, st_q.slotMap[entryNo]};
            end else if (statHit) begin
                st_d.rdata = {15'h0000, st_q.inFrame, st_q.frameCnt};
            end else begin
                st_d.rdata = 32'h00000000;
            end
        end
        // writes land only at the completing edge; bits 31:8 dropped,
        // status and unmapped indices are not writable
        if (psel && penable && st_q.ready && pwrite && mapHit) begin
            st_d.slotMap[entryNo] = pwdata[ENTRY_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    // reset loads constants only; every entry starts disabled
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.slotMap <= {NUM_SLOTS{ENTRY_RST}};
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    // each output is one field of the state register, no logic
    assign prdata = st_q.rdata;
    assign pready = st_q.ready;
    assign pslverr = st_q.slvErr;
    assign chanData = st_q.chanOut;
    assign chanUpdate = st_q.chanPulse;

endmodule // ftm_input_mapper

// ---- test/ftm_src_model.sv ----
// two-pin serial source for the mapper, msb first
// assumes go is a one-clk pulse with both frames held stable
`timescale 1ns/100ps
module ftm_src_model (
    // clock and request
    input wire logic clk,
    input wire logic go,
    input wire logic [511:0] frameA,
    input wire logic [511:0] frameB,
    // serial pins
    output logic bitClk = 1'b0,
    output logic frameSync = 1'b0,
    output logic sdA = 1'b0,
    output logic sdB = 1'b1,
    output logic busy = 1'b0
);
    ////////////////////////////////////////
    // bit clock only inside frames; idle data keeps toggling
    initial forever begin
        @(posedge clk);
        if (go) begin
            busy <= 1'b1;
            for (int j = 0; j < 512; j++) begin
                sdA <= frameA[511-j];
                sdB <= frameB[511-j];
                frameSync <= (j == 0);
                repeat (4) @(posedge clk);
                bitClk <= 1'b1;
                repeat (4) @(posedge clk);
                bitClk <= 1'b0;
            end
            busy <= 1'b0;
        end else begin
            sdA <= ~sdA;
            sdB <= ~sdB;
        end
    end
endmodule // ftm_src_model

// ---- test/ftm_input_mapper_chk.sv ----
// port checker for the mapper
// assumes one clock and an async active-high reset
`timescale 1ns/100ps
module ftm_chk import ftm_pkg::*; #(parameter int NUM_CHANS = CHANS) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // channels
    input wire logic [NUM_CHANS*CHAN_W-1:0] chanData,
    input wire logic chanUpdate
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] regIdx; // register index of the address
    logic inMap; // index inside the entry block
    assign regIdx = paddr[ADDR_W-1:IDX_LSB];
    assign inMap = regIdx >= MAP_BASE_IDX && regIdx <= MAP_LAST_IDX;
    ////////////////////////////////////////
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held");
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("stray ready");
    err_decode_a: assert property (pready |->
        pslverr == !(inMap || regIdx == STAT_IDX))
        else $error("bad decode");
    err_zero_a: assert property (pslverr |-> prdata == 0)
        else $error("error data");
    rsvd_zero_a: assert property (pready && inMap && !pwrite |->
        prdata[31:8] == 0)
        else $error("reserved bits");
    update_pulse_a: assert property (chanUpdate |=> !chanUpdate)
        else $error("long update");
    channel_hold_a: assert property (!chanUpdate |->
        $stable(chanData))
        else $error("channel moved");
endmodule // ftm_chk
bind ftm_input_mapper ftm_chk #(.NUM_CHANS(NUM_CHANS)) ftm_chk_i (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chanData(chanData), .chanUpdate(chanUpdate));

// ---- test/ftm_input_mapper_bench.sv ----
// bench: apb map setup, three frames, channel compare
// assumes source model and checker are compiled first
`timescale 1ns/100ps
module ftm_input_mapper_bench import ftm_pkg::*; ;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, bitClk, frameSync, sdA, sdB, busy, chanUpdate;
    logic [511:0] chanData, frA = '0, frB = '0, expQ = '0;
    logic [7:0] b; // expected byte
    logic [7:0] cfg [5] = '{8'h80, 8'hff, 8'h01, 8'h8e, 8'ha9}; // entries
    logic [15:0] slot [5] = '{16'd0, 16'd1, 16'd2, 16'd63, 16'd5};
    int miscompares = 0, nChecks = 0, upd;
    always #50 clk = ~clk;
    ftm_input_mapper ftm_input_mapper_i (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bitClk(bitClk), .frameSync(frameSync), .flex_serial_input_a(sdA),
        .flex_serial_input_b(sdB), .chanData(chanData),
        .chanUpdate(chanUpdate));
    ftm_src_model ftm_src_model_i (.clk(clk), .go(go), .frameA(frA),
        .frameB(frB), .bitClk(bitClk), .frameSync(frameSync), .sdA(sdA),
        .sdB(sdB), .busy(busy));
    ////////////////////////////////////////
    task automatic check(input logic [511:0] seen, exp, input string what);
        nChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d miscompares %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one apb transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        repeat (20) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                @(posedge clk);
                return;
            end
        end
        check(0, 1, "apb wait");
        final_report();
    endtask
    // one frame from the source, counting update pulses
    task automatic send_frame();
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        upd = 0;
        repeat (6000) begin
            @(posedge clk);
            upd += (chanUpdate === 1'b1);
            if (busy === 1'b0) return;
        end
        check(0, 1, "frame wait");
        final_report();
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        check(chanData, '0, "reset channels");
        apb(1'b0, MAP_LAST_IDX, '0);
        check(rd, '0, "entry reset");
        apb(1'b0, STAT_IDX, '0);
        check({err, rd}, 33'h0, "status reset");
        apb(1'b0, STAT_IDX + 16'h1, '0);
        check({err, rd}, {1'b1, 32'h0}, "unmapped");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, MAP_BASE_IDX + slot[i], {24'hffffff, cfg[i]});
            apb(1'b0, MAP_BASE_IDX + slot[i], '0);
            check({err, rd}, {1'b0, 24'h0, cfg[i]}, "entry");
        end
        for (int r = 0; r < 3; r++) begin
            if (r == 1) begin
                // drop slot 0 so its lane must fall back to zero
                cfg[0] = 8'h00;
                apb(1'b1, MAP_BASE_IDX + slot[0], '0);
            end
            for (int n = 0; n < 64; n++) begin
                frA[511-8*n -: 8] <= 8'(n * 5 + r);
                frB[511-8*n -: 8] <= 8'(n * 11 + r);
            end
            send_frame();
            check(upd, r > 0, "updates");
            if (r > 0) begin
                check(chanData, expQ, "channels");
            end
            expQ = '0;
            for (int i = 0; i < 5; i++) begin
                b = cfg[i][5] ? frB[511-8*slot[i] -: 8]
                    : frA[511-8*slot[i] -: 8];
                if (cfg[i][6]) b = {<<{b}};
                if (cfg[i][7]) begin
                    expQ[32*cfg[i][5:2] + 24 - 8*cfg[i][1:0] +: 8] = b;
                end
            end
        end
        apb(1'b0, STAT_IDX, '0);
        check({err, rd}, 33'h3, "status");
        final_report();
    end
endmodule // ftm_input_mapper_bench
